// ---- dv/rtswr_host.sv ----
module rtswr_host (
	input wire clk,
	input wire [15:0] regRdata_reg,
	output logic [15:0] regAddr,
	output logic regWrite,
	output logic regRead,
	output logic [15:0] regWdata
);
	timeunit 1ns;
	timeprecision 1ns;
	int readCount = 0;
	initial begin
		regAddr = 16'h0000;
		regWrite = 1'b0;
		regRead = 1'b0;
		regWdata = 16'h0000;
	end
	// Idle buses park on the inverse value, so a stale word never reads as a match.
	task automatic wr(input [15:0] a, input [15:0] d);
		regAddr = a;
		regWdata = d;
		regWrite = 1'b1;
		@(posedge clk);
		#10;
		regWrite = 1'b0;
		regAddr = ~a;
		regWdata = ~d;
		// An idle edge keeps a following call from driving the same signals again at once.
		@(posedge clk);
		#10;
	endtask
	task automatic rd(input [15:0] a, output [15:0] d);
		readCount++;
		regAddr = a;
		regRead = 1'b1;
		@(posedge clk);
		#10;
		regRead = 1'b0;
		regAddr = ~a;
		@(posedge clk);
		#10;
		d = regRdata_reg;
	endtask
endmodule

// ---- dv/rtswr_status_properties.sv ----
`include "rtswr_defs.vh"
module rtswr_status_properties (
	input wire clk,
	input wire rst_b,
	input wire terminalSoftReset,
	input wire [15:0] regAddr,
	input wire regWrite,
	input wire regRead,
	input wire [15:0] regRdata_reg,
	input wire messageErrorIn,
	input wire subsystemFailInput,
	input wire statusStart,
	input wire statusRepeat,
	input wire [`RTSWR_WORD_WIDTH-1:0] statusWord,
	input wire busyActive_reg,
	input wire [15:0] descriptorBase
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	chk_base_zero: assert property (descriptorBase[15] == 1'b0 && descriptorBase[8:0] == 9'h000)
		else $error("Base fixed bits set");
	chk_base_soft: assert property (terminalSoftReset |=> descriptorBase == 16'h0400)
		else $error("Base not reinitialised");
	chk_base_hold: assert property (!(regWrite && regAddr == 16'h0019) && !terminalSoftReset
		|=> $stable(descriptorBase)) else $error("Base changed alone");
	chk_stat_rsvd: assert property (regRead && regAddr == 16'h001A
		|=> regRdata_reg[14:11] == 4'h0 && regRdata_reg[7:5] == 3'h0) else $error("Reserved set");
	chk_msg_error: assert property (regRead && regAddr == 16'h001A && !terminalSoftReset
		&& !$past(terminalSoftReset) |=> regRdata_reg[10] == $past(messageErrorIn, 2))
		else $error("Error flag wrong");
	chk_repeat_keep: assert property (statusStart && statusRepeat && !terminalSoftReset
		|=> $stable(statusWord)) else $error("Repeat changed word");
	chk_fail_or: assert property (statusStart && !statusRepeat && subsystemFailInput
		&& !terminalSoftReset |=> statusWord[2]) else $error("Fail input lost");
	chk_busy_word: assert property (statusStart && !statusRepeat && busyActive_reg
		&& !terminalSoftReset |=> statusWord[3]) else $error("Busy lost");
	chk_soft_clear: assert property (terminalSoftReset[*2] |=> statusWord == 11'h000
		&& !busyActive_reg) else $error("Soft reset left bits");
endmodule
bind rtswr_status_regs rtswr_status_properties i_chk (.clk, .rst_b, .terminalSoftReset,
	.regAddr, .regWrite, .regRead, .regRdata_reg, .messageErrorIn, .subsystemFailInput,
	.statusStart, .statusRepeat, .statusWord, .busyActive_reg, .descriptorBase);

// ---- dv/testbench.sv ----
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic terminalSoftReset = 1'b0, messageErrorIn = 1'b0, broadcastReceivedIn = 1'b0;
	logic subsystemFailInput = 1'b0, vectorWordOption = 1'b0, vectorWordCmd = 1'b0;
	logic statusStart = 1'b0, statusRepeat = 1'b0, statusSent = 1'b0;
	wire [15:0] regAddr, regWdata, regRdata_reg, descriptorBase;
	wire regWrite, regRead, regRdValid_reg, busyActive_reg;
	wire [10:0] statusWord;
	logic [15:0] got;
	int failures = 0, check_count = 0, cycles = 0;
	int rdValids = 0;
	logic [15:0] rows [0:4][0:2] = '{'{16'h0019, 16'hFFFF, 16'h7E00},
		'{16'h0019, 16'h1234, 16'h1200}, '{16'h001A, 16'hFFFF, 16'h830F},
		'{16'h001A, 16'h0000, 16'h0000}, '{16'h0055, 16'hFFFF, 16'h0000}};
	rtswr_status_regs i_dut (.clk, .rst_b, .terminalSoftReset, .regAddr, .regWrite, .regRead,
		.regWdata, .regRdata_reg, .regRdValid_reg, .messageErrorIn, .broadcastReceivedIn,
		.subsystemFailInput, .vectorWordOption, .vectorWordCmd, .statusStart, .statusRepeat,
		.statusSent, .statusWord, .busyActive_reg, .descriptorBase);
	rtswr_host i_host (.clk, .regRdata_reg, .regAddr, .regWrite, .regRead, .regWdata);
	initial begin
		forever #50 clk = ~clk;
	end
	task check(input [15:0] seen, input [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task report_and_stop;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task step;
		@(posedge clk);
		#10;
	endtask
	// A hung wait must still reach the verdict.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			report_and_stop();
		end
	end
	// Counted on the falling edge, where the registered valid has settled.
	always @(negedge clk) begin
		if (regRdValid_reg === 1'b1) begin
			rdValids++;
		end
	end
	initial begin
		repeat (3) @(posedge clk);
		#10;
		rst_b = 1'b1;
		i_host.rd(16'h0019, got);
		check(got, 16'h0400);
		i_host.rd(16'h001A, got);
		check(got, 16'h0000);
		for (int i = 0; i < 5; i++) begin
			i_host.wr(rows[i][0], rows[i][1]);
			i_host.rd(rows[i][0], got);
			check(got, rows[i][2]);
		end
		i_host.wr(16'h0019, 16'h7E00);
		i_host.wr(16'h001A, 16'h830F);
		terminalSoftReset = 1'b1;
		step();
		step();
		terminalSoftReset = 1'b0;
		i_host.rd(16'h0019, got);
		check(got, 16'h0400);
		i_host.rd(16'h001A, got);
		check(got, 16'h0000);
		i_host.wr(16'h001A, 16'h8208);
		check({15'h0000, busyActive_reg}, 16'h0001);
		statusStart = 1'b1;
		step();
		statusStart = 1'b0;
		check({5'h00, statusWord}, 16'h0208);
		statusSent = 1'b1;
		step();
		statusSent = 1'b0;
		i_host.rd(16'h001A, got);
		check(got, 16'h0000);
		statusStart = 1'b1;
		statusRepeat = 1'b1;
		step();
		statusStart = 1'b0;
		statusRepeat = 1'b0;
		check({5'h00, statusWord}, 16'h0208);
		i_host.wr(16'h001A, 16'h0300);
		statusStart = 1'b1;
		step();
		statusStart = 1'b0;
		statusSent = 1'b1;
		step();
		statusSent = 1'b0;
		i_host.rd(16'h001A, got);
		check(got, 16'h0300);
		messageErrorIn = 1'b1;
		broadcastReceivedIn = 1'b1;
		step();
		i_host.rd(16'h001A, got);
		check(got, 16'h0710);
		messageErrorIn = 1'b0;
		broadcastReceivedIn = 1'b0;
		i_host.wr(16'h001A, 16'h8200);
		statusStart = 1'b1;
		statusRepeat = 1'b1;
		step();
		statusStart = 1'b0;
		statusRepeat = 1'b0;
		statusSent = 1'b1;
		step();
		statusSent = 1'b0;
		i_host.rd(16'h001A, got);
		check(got, 16'h8200);
		i_host.wr(16'h001A, 16'h0004);
		vectorWordOption = 1'b1;
		vectorWordCmd = 1'b1;
		step();
		vectorWordCmd = 1'b0;
		vectorWordOption = 1'b0;
		i_host.rd(16'h001A, got);
		check(got, 16'h0004);
		vectorWordCmd = 1'b1;
		step();
		vectorWordCmd = 1'b0;
		i_host.rd(16'h001A, got);
		check(got, 16'h0000);
		subsystemFailInput = 1'b1;
		statusStart = 1'b1;
		step();
		statusStart = 1'b0;
		check({5'h00, statusWord}, 16'h0004);
		i_host.wr(16'h0019, 16'h5A00);
		check(descriptorBase, 16'h5A00);
		i_host.wr(16'h001A, 16'h0208);
		rst_b = 1'b0;
		step();
		rst_b = 1'b1;
		check({5'h00, statusWord}, 16'h0000);
		check({15'h0000, busyActive_reg}, 16'h0000);
		i_host.rd(16'h0019, got);
		check(got, 16'h0400);
		i_host.rd(16'h001A, got);
		check(got, 16'h0000);
		check(rdValids[15:0], i_host.readCount[15:0]);
		report_and_stop();
	end
endmodule

// ---- include/rtswr_defs.vh ----
`ifndef RTSWR_DEFS_VH
`define RTSWR_DEFS_VH

// ----------------------------------------
// Register offsets on the register port.
// ----------------------------------------
`define RTSWR_BASE_ADDR 16'h0019
`define RTSWR_STAT_ADDR 16'h001A

// ----------------------------------------
// Descriptor table base register.
// ----------------------------------------
`define RTSWR_BASE_RESET 16'h0400
`define RTSWR_BASE_WMASK 16'h7E00

// ----------------------------------------
// Status word bits register layout.
// ----------------------------------------
`define RTSWR_STAT_RESET 16'h0000
`define RTSWR_STAT_WMASK 16'h830F
`define RTSWR_BIT_SEND_CLEAR 15
`define RTSWR_BIT_MSG_ERROR 10
`define RTSWR_BIT_INSTR 9
`define RTSWR_BIT_SVC_REQ 8
`define RTSWR_BIT_BCAST 4
`define RTSWR_BIT_BUSY 3
`define RTSWR_BIT_SUBSYS_FAIL 2
`define RTSWR_BIT_BUS_CTRL 1
`define RTSWR_BIT_TERM_FLAG 0
`define RTSWR_WORD_WIDTH 11

`endif

// ---- src/rtswr_base_reg.v ----
`include "rtswr_defs.vh"

module rtswr_base_reg (
	input wire clk,
	input wire rst_b,
	input wire softReset,
	input wire wrEn,
	input wire [15:0] wrData,
	output reg [15:0] baseValue_reg
);

	// ----------------------------------------
	// Base address storage.
	// ----------------------------------------
	// Only host writes and terminal soft reset change the value once master reset has passed.
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			baseValue_reg <= `RTSWR_BASE_RESET; // RL1
		end else if (softReset) begin
			baseValue_reg <= `RTSWR_BASE_RESET; // RL1
		end else if (wrEn) begin
			baseValue_reg <= wrData & `RTSWR_BASE_WMASK; // RL2 RL3
		end
	end

endmodule

// ---- src/rtswr_status_regs.v ----
// Summary of operation
// RL1: Base address register resets to 0x0400 on master or soft reset, then host-written.
// RL2: Base register bit 15 and bits 8:0 ignore writes and read zero.
// RL3: Device never changes base address itself after reset.
// RL4: Status bits register clears on master reset and on terminal soft reset.
// RL5: Status bits 14:11 and 7:5 ignore writes and read zero.
// RL6: Status bits 10:0 form bits 10:0 of every outgoing status word.
// RL7: Host bits persist in status words until overwritten, unless send-then-clear set.
// RL8: Send-then-clear clears itself and bits 9:5, 3:0 after next status word.
// RL9: Send-then-clear leaves transmit-status and transmit-last-command responses undisturbed.
// RL10: Message error bit 10 is device-driven and host cannot write it.
// RL11: Broadcast received bit 4 is device-driven and read-only to host.
// RL12: Host keeps writable status bits current; device alters them only by clear.
// RL13: All status flags are active high.
// RL14: Busy bit makes terminal report busy and withhold transmit data words.
// RL15: Sent subsystem fail is register bit 2 ORed with the fail input.
// RL16: Vector word command with option zero clears subsystem fail before status.
// RL17: Host sets bus control accept bit to accept dynamic bus control.
// RL18: Status contents are sampled when serialising starts; later writes affect later words.
`include "rtswr_defs.vh"

module rtswr_status_regs (
	input wire clk,
	input wire rst_b,
	input wire terminalSoftReset,
	input wire [15:0] regAddr,
	input wire regWrite,
	input wire regRead,
	input wire [15:0] regWdata,
	output reg [15:0] regRdata_reg,
	output reg regRdValid_reg,
	input wire messageErrorIn,
	input wire broadcastReceivedIn,
	input wire subsystemFailInput,
	input wire vectorWordOption,
	input wire vectorWordCmd,
	input wire statusStart,
	input wire statusRepeat,
	input wire statusSent,
	output wire [`RTSWR_WORD_WIDTH-1:0] statusWord,
	output reg busyActive_reg,
	output wire [15:0] descriptorBase
);

	// ----------------------------------------
	// Helpers.
	// ----------------------------------------
	function [15:0] maskedMerge;
		input [15:0] oldValue;
		input [15:0] newValue;
		input [15:0] mask;
		begin
			maskedMerge = (oldValue & ~mask) | (newValue & mask);
		end
	endfunction

	function addrHit;
		input [15:0] addr;
		input [15:0] target;
		begin
			addrHit = (addr == target);
		end
	endfunction

	// ----------------------------------------
	// Decode.
	// ----------------------------------------
	wire baseWrite;
	wire statWrite;
	assign baseWrite = regWrite && addrHit(regAddr, `RTSWR_BASE_ADDR);
	assign statWrite = regWrite && addrHit(regAddr, `RTSWR_STAT_ADDR);

	// ----------------------------------------
	// Descriptor table base.
	// ----------------------------------------
	rtswr_base_reg baseInst (
		.clk(clk),
		.rst_b(rst_b),
		.softReset(terminalSoftReset),
		.wrEn(baseWrite),
		.wrData(regWdata),
		.baseValue_reg(descriptorBase)
	);

	// ----------------------------------------
	// Status word bits storage.
	// ----------------------------------------
	reg [15:0] hostBits_reg;
	reg [15:0] hostBits_next;
	reg messageErrorFlag_reg;
	reg broadcastReceivedFlag_reg;
	reg lastWasRepeat_reg;
	reg lastWasRepeat_next;
	wire sendThenClear;
	wire vectorClear;
	wire normalSent;

	assign sendThenClear = hostBits_reg[`RTSWR_BIT_SEND_CLEAR];
	assign vectorClear = vectorWordCmd && !vectorWordOption;
	// A repeat response must not consume the clear request.
	assign normalSent = statusSent && !lastWasRepeat_reg; // RL9

	always @* begin
		hostBits_next = hostBits_reg; // RL7 RL12
		if (normalSent && sendThenClear) begin
			hostBits_next = `RTSWR_STAT_RESET; // RL8
		end
		if (vectorClear) begin
			hostBits_next[`RTSWR_BIT_SUBSYS_FAIL] = 1'b0; // RL16
		end
		// A host write in the same cycle wins, as it is the newer intent.
		if (statWrite) begin
			hostBits_next = maskedMerge(16'h0000, regWdata, `RTSWR_STAT_WMASK); // RL5 RL10 RL11
		end
	end

	always @* begin
		lastWasRepeat_next = lastWasRepeat_reg;
		if (statusStart) begin
			lastWasRepeat_next = statusRepeat;
		end
	end

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			hostBits_reg <= `RTSWR_STAT_RESET; // RL4
			messageErrorFlag_reg <= 1'b0;
			broadcastReceivedFlag_reg <= 1'b0;
			lastWasRepeat_reg <= 1'b0;
		end else if (terminalSoftReset) begin
			hostBits_reg <= `RTSWR_STAT_RESET; // RL4
			messageErrorFlag_reg <= 1'b0;
			broadcastReceivedFlag_reg <= 1'b0;
			lastWasRepeat_reg <= 1'b0;
		end else begin
			hostBits_reg <= hostBits_next;
			messageErrorFlag_reg <= messageErrorIn; // RL10
			broadcastReceivedFlag_reg <= broadcastReceivedIn; // RL11
			lastWasRepeat_reg <= lastWasRepeat_next;
		end
	end

	// ----------------------------------------
	// Outgoing status word.
	// ----------------------------------------
	wire subsysFailBit;
	wire [`RTSWR_WORD_WIDTH-1:0] liveWord;
	wire [15:0] statReadValue;

	// The vector clear is folded in so a same-cycle start already sees it.
	assign subsysFailBit = (hostBits_reg[`RTSWR_BIT_SUBSYS_FAIL] && !vectorClear)
		|| subsystemFailInput; // RL15 RL16
	assign liveWord = {messageErrorFlag_reg,
		hostBits_reg[`RTSWR_BIT_INSTR],
		hostBits_reg[`RTSWR_BIT_SVC_REQ],
		3'b000,
		broadcastReceivedFlag_reg,
		hostBits_reg[`RTSWR_BIT_BUSY],
		subsysFailBit,
		hostBits_reg[`RTSWR_BIT_BUS_CTRL],
		hostBits_reg[`RTSWR_BIT_TERM_FLAG]}; // RL6 RL13 RL17

	// Repeat responses keep the snapshot, so a pending clear shows no effect on them.
	rtswr_word_snap snapInst (
		.clk(clk),
		.rst_b(rst_b),
		.softReset(terminalSoftReset),
		.capture(statusStart && !statusRepeat), // RL18 RL9
		.liveWord(liveWord),
		.word_reg(statusWord)
	);

	assign statReadValue = {hostBits_reg[15], 4'h0, messageErrorFlag_reg,
		hostBits_reg[9:8], 3'b000, broadcastReceivedFlag_reg,
		hostBits_reg[3:0]}; // RL5

	// ----------------------------------------
	// Busy and read port.
	// ----------------------------------------
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			busyActive_reg <= 1'b0;
			regRdata_reg <= 16'h0000;
			regRdValid_reg <= 1'b0;
		end else begin
			busyActive_reg <= hostBits_next[`RTSWR_BIT_BUSY] && !terminalSoftReset; // RL14
			regRdValid_reg <= regRead;
			if (regRead) begin
				if (addrHit(regAddr, `RTSWR_BASE_ADDR)) begin
					regRdata_reg <= descriptorBase; // RL2
				end else if (addrHit(regAddr, `RTSWR_STAT_ADDR)) begin
					regRdata_reg <= statReadValue;
				end else begin
					regRdata_reg <= 16'h0000;
				end
			end
		end
	end

endmodule

// ---- src/rtswr_word_snap.v ----
`include "rtswr_defs.vh"

module rtswr_word_snap (
	input wire clk,
	input wire rst_b,
	input wire softReset,
	input wire capture,
	input wire [`RTSWR_WORD_WIDTH-1:0] liveWord,
	output reg [`RTSWR_WORD_WIDTH-1:0] word_reg
);

	// ----------------------------------------
	// Snapshot of the word being serialised.
	// ----------------------------------------
	// Holding the last sent word lets repeat responses return it unchanged.
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			word_reg <= {`RTSWR_WORD_WIDTH{1'b0}};
		end else if (softReset) begin
			word_reg <= {`RTSWR_WORD_WIDTH{1'b0}};
		end else if (capture) begin
			word_reg <= liveWord; // RL18
		end
	end

endmodule
